/* logic/sadc_params.svh */
/*
 constants of the sar converter sequencer: register indices, field
 positions, reset values and conversion timing.
 assumes it is included by bare name before any module that uses it.
*/
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
// Functional notes
// [R01] selected channel pin leaves port control and becomes the converter input
// [R02] port output and direction writes do not reach the selected pin
// [R03] reading the port bit of the selected pin returns 0
// [R04] ref_high converts to FF, ref_low to 00, linear between, saturates high
// [R05] status/control write starts a conversion lasting 16 to 17 converter clocks
// [R06] continuous mode overwrites the result register after every conversion
// [R07] continuous mode restarts after each conversion until its bit clears
// [R08] continuous mode sets the complete flag after the first conversion only
// [R09] single mode converts once per status/control write, then idles
// [R10] interrupt enabled: request per conversion, to cpu on 0, dma on 1
// [R11] interrupt disabled: complete bit read-only, set on done, cleared by access
// [R12] interrupt enabled: complete bit is a writable service selector, reset clears
// [R13] data read or status/control write withdraws a pending interrupt
// [R14] reset clears interrupt enable and continuous bits
// [R15] five-bit channel field; all ones powers the converter down
// [R16] converter keeps running in wait mode; its cpu request can wake
// [R17] stop mode aborts and idles the converter; conversions resume afterwards
// [R18] software should set the converter clock near 1 MHz
// [R19] software must not select dma service while interrupts are enabled
// [R20] software should discard one conversion after leaving stop mode
// [R21] software should power the converter down before wait when unused
// [R22] the single 8-bit result register updates on every completion
// [R23] divider field divides by 1, 2, 4, 8, or 16 when its top bit set
// [R24] reset selects the oscillator clock as converter clock source
// [R25] the first result after power-up is marked as settling
// [R26] codes 0 to 5 pick pins in order; other unused codes are reserved
`define SADC_IDX_SCR      8'h3C
`define SADC_IDX_DATA     8'h3D
`define SADC_IDX_CLK      8'h3E
`define SADC_IDX_PORT     8'h3F
`define SADC_IDX_DDR      8'h40
`define SADC_SCR_CMPL     7
`define SADC_SCR_IRQEN    6
`define SADC_SCR_CONT     5
`define SADC_CLK_DIV_HI   7
`define SADC_CLK_DIV_LO   5
`define SADC_CLK_SRC      4
`define SADC_CLK_SETTLE   0
`define SADC_SCR_RST      8'h1F
`define SADC_CLK_RST      8'h00
`define SADC_CH_REFH      5'h1D
`define SADC_CH_REFL      5'h1E
`define SADC_CH_OFF       5'h1F
`define SADC_NUM_PINS     6
`define SADC_RES_BITS     8
`define SADC_SAMPLE_TICKS 8
`define SADC_CONV_TICKS   5'h10
`endif

/* logic/sadc_pkg.sv */
/*
 types of the sar converter sequencer: bus request carrier, control
 register layout and the conversion state machine codes.
 assumes nothing beyond a sv compiler.
*/
package sadc_pkg;
   typedef struct packed {
      logic [9:0]  address;
      logic        read;
      logic        write;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } sadc_avl_req_type;

   typedef struct packed {
      logic       complete_or_service_select;
      logic       conv_irq_enable;
      logic       continuous_enable;
      logic [4:0] channel_select;
   } sadc_scr_type;

   typedef enum logic [2:0] {
      SAR_IDLE   = 3'h1,
      SAR_SAMPLE = 3'h2,
      SAR_CONV   = 3'h4
   } sadc_sar_state_type;
endpackage

/* logic/sadc_clkdiv.sv */
/*
 converter clock divider: turns the selected source enable into a
 converter tick, one clock wide.
 assumes src_en is a one-cycle enable in the clk domain.
*/
`timescale 1ns/1ps
module sadc_clkdiv (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       src_en,
   input  wire logic [2:0] div_sel,
   output logic            tick
);
   logic [3:0] cnt_q;

   function automatic logic [3:0] last_count(input logic [2:0] sel);
      logic [3:0] r;
      r = 4'hF;
      if (!sel[2]) begin
         r = (4'h1 << sel[1:0]) - 4'h1;
      end
      return r;
   endfunction

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_q <= 4'h0;
         tick  <= 1'h0;
      end else begin
         tick <= 1'h0;
         if (src_en) begin
            // divide by 1, 2, 4, 8, or 16 with top bit set [R23]
            if (cnt_q >= last_count(div_sel)) begin
               cnt_q <= 4'h0;
               tick  <= 1'h1;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end
endmodule

/* logic/sadc_sar.sv */
/*
 successive approximation engine: sample phase then one bit per tick.
 assumes an external comparator answers dac_code within one clk.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_sar #(
   parameter int RES_BITS     = `SADC_RES_BITS,
   parameter int SAMPLE_TICKS = `SADC_SAMPLE_TICKS
) (
   input  wire logic                clk,
   input  wire logic                srst,
   input  wire logic                tick,
   input  wire logic                start,
   input  wire logic                abort,
   input  wire logic                cmp_above,
   output logic                     busy,
   output logic                     done,
   output logic [RES_BITS-1:0]      result,
   output logic [RES_BITS-1:0]      dac_code
);
   import sadc_pkg::*;
   localparam int BW = $clog2(RES_BITS);

   sadc_sar_state_type  state_q;
   logic [4:0]          cnt_q;
   logic [BW-1:0]       bit_q;
   logic [RES_BITS-1:0] code_d;
   logic [4:0]          tick_cnt_q;
   logic                armed_q;

   assign busy = state_q != SAR_IDLE;

   always_comb begin
      code_d = dac_code;
      code_d[bit_q] = cmp_above;
      if (bit_q != '0) begin
         code_d[bit_q - 1'h1] = 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q  <= SAR_IDLE;
         cnt_q    <= 5'h00;
         bit_q    <= '0;
         dac_code <= '0;
         result   <= '0;
         done     <= 1'h0;
      end else begin
         done <= 1'h0;
         if (abort) begin
            state_q <= SAR_IDLE;
         end else if (start) begin
            // a start arrives anywhere in a tick period: 16 to 17 periods [R05]
            state_q <= SAR_SAMPLE;
            cnt_q   <= 5'h00;
         end else if (tick && armed_q) begin
            unique case (state_q)
               SAR_IDLE: begin
               end
               SAR_SAMPLE: begin
                  if (cnt_q == 5'(SAMPLE_TICKS - 1)) begin
                     state_q  <= SAR_CONV;
                     dac_code <= {1'h1, {(RES_BITS-1){1'h0}}};
                     bit_q    <= BW'(RES_BITS - 1);
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
               SAR_CONV: begin
                  // comparator always above gives all ones: saturation [R04]
                  dac_code <= code_d;
                  if (bit_q == '0) begin
                     result  <= code_d;
                     done    <= 1'h1;
                     state_q <= SAR_IDLE;
                  end else begin
                     bit_q <= bit_q - 1'h1;
                  end
               end
            endcase
         end
      end
   end

   // the tick period cut by the start is not counted, else it would last 15 to 16 [R05]
   always_ff @(posedge clk) begin
      if (srst || start) begin
         armed_q <= 1'h0;
      end else if (tick) begin
         armed_q <= 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || start) begin
         tick_cnt_q <= 5'h00;
      end else if (tick && armed_q && busy) begin
         tick_cnt_q <= tick_cnt_q + 5'h01;
      end
   end

   a_conv_length: assert property ( // [R05]
      @(posedge clk) disable iff (srst) done |-> tick_cnt_q == `SADC_CONV_TICKS)
      else $error("conversion did not take 16 converter ticks");

   a_abort_idles: assert property ( // [R17]
      @(posedge clk) disable iff (srst) abort |=> !busy && !done)
      else $error("abort left the engine running");
endmodule

/* logic/sadc_top.sv */
/*
 sar converter sequencer: avalon-mm register slave, channel and port pin
 takeover, single and continuous sequencing, completion flag, interrupt
 routing, power-off and stop handling.
 assumes one clk; osc_clock is a one-cycle enable from the oscillator,
 cmp_above comes from the analog comparator, stop_mode from the core.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module sadc_top (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire sadc_pkg::sadc_avl_req_type avl_req,
   output logic [31:0]                     readdata,
   output logic                            waitrequest,
   input  wire logic                       osc_clock,
   input  wire logic                       stop_mode,
   input  wire logic                       cmp_above,
   input  wire logic [`SADC_NUM_PINS-1:0]  pin_in,
   output logic [`SADC_NUM_PINS-1:0]       pin_out,
   output logic [`SADC_NUM_PINS-1:0]       pin_oe,
   output logic [`SADC_NUM_PINS-1:0]       analog_sel,
   output logic [7:0]                      dac_code,
   output logic                            adc_power,
   output logic                            irq_cpu,
   output logic                            irq_dma
);
   import sadc_pkg::*;
   localparam int NP = `SADC_NUM_PINS;

   sadc_scr_type  scr_q;
   logic [7:0]    clksel_q;
   logic [7:0]    result_q;
   logic [NP-1:0] port_out_q;
   logic [NP-1:0] port_ddr_q;
   logic          first_done_q;
   logic          irq_pend_q;
   logic          settle_pend_q;
   logic          settling_q;
   logic          resume_q;
   logic          stop_q;
   logic [7:0]    idx;
   logic          aligned;
   logic          accept;
   logic          wr_en;
   logic          rd_en;
   logic          wr_scr;
   logic          rd_data;
   logic [7:0]    wbyte;
   logic [NP-1:0] sel_mask;
   logic          chan_off;
   logic          new_off;
   logic          sar_start;
   logic          sar_abort;
   logic          sar_busy;
   logic          sar_done;
   logic          cmp_eff;
   logic          div_src;
   logic          div_tick;
   logic [7:0]    sar_result;
   logic [7:0]    rd_mux;

   function automatic logic [NP-1:0] pin_mask(input logic [4:0] ch);
      logic [NP-1:0] m;
      m = '0;
      if (ch < 5'(NP)) begin
         m = NP'(1) << ch;
      end
      return m;
   endfunction

   assign idx     = avl_req.address[9:2];
   assign aligned = avl_req.address[1:0] == 2'h0;
   assign accept  = (avl_req.read | avl_req.write) & ~waitrequest;
   assign wr_en   = accept & avl_req.write & avl_req.byteenable[0] & aligned;
   assign rd_en   = accept & avl_req.read & aligned;
   assign wbyte   = avl_req.writedata[7:0];
   assign wr_scr  = wr_en & (idx == `SADC_IDX_SCR);
   assign rd_data = rd_en & (idx == `SADC_IDX_DATA);

   // codes 0 to 5 pick pins in ascending order, the rest pick none [R26] [R01]
   assign sel_mask = pin_mask(scr_q.channel_select);
   assign chan_off = scr_q.channel_select == `SADC_CH_OFF;
   assign new_off  = wbyte[4:0] == `SADC_CH_OFF;

   // nothing here looks at wait mode: conversions run on through it [R16]
   always_comb begin
      sar_start = 1'h0;
      if (stop_mode) begin
         sar_start = 1'h0;
      end else if (wr_scr) begin
         sar_start = !new_off; // [R05] [R09] [R15]
      end else if (!chan_off) begin
         sar_start = (sar_done & scr_q.continuous_enable) | resume_q; // [R07] [R17]
      end
   end

   // a write that leaves the off code must not be aborted by the old code
   assign sar_abort = stop_mode | (chan_off & !wr_scr); // [R15] [R17]

   // references are forced digitally, reserved codes convert to zero
   always_comb begin
      cmp_eff = 1'h0;
      if (scr_q.channel_select == `SADC_CH_REFH) begin
         cmp_eff = 1'h1; // [R04]
      end else if (scr_q.channel_select == `SADC_CH_REFL) begin
         cmp_eff = 1'h0; // [R04]
      end else if (scr_q.channel_select < 5'(NP)) begin
         cmp_eff = cmp_above;
      end
   end

   // source 0 is the oscillator, the reset choice [R24]
   assign div_src = clksel_q[`SADC_CLK_SRC] ? 1'h1 : osc_clock;

   sadc_clkdiv u_div (
      .clk     (clk),
      .srst    (srst),
      .src_en  (div_src),
      .div_sel (clksel_q[`SADC_CLK_DIV_HI:`SADC_CLK_DIV_LO]),
      .tick    (div_tick)
   );

   sadc_sar #(
      .RES_BITS     (8),
      .SAMPLE_TICKS (`SADC_SAMPLE_TICKS)
   ) u_sar (
      .clk       (clk),
      .srst      (srst),
      .tick      (div_tick),
      .start     (sar_start),
      .abort     (sar_abort),
      .cmp_above (cmp_eff),
      .busy      (sar_busy),
      .done      (sar_done),
      .result    (sar_result),
      .dac_code  (dac_code)
   );

   always_comb begin
      rd_mux = 8'h00;
      if (aligned) begin
         case (idx)
            `SADC_IDX_SCR:  rd_mux = scr_q;
            `SADC_IDX_DATA: rd_mux = result_q;
            `SADC_IDX_CLK:  rd_mux = {clksel_q[7:4], 3'h0, settling_q};
            // the converter's own pin reads as zero [R03]
            `SADC_IDX_PORT: rd_mux = 8'(((port_ddr_q & port_out_q)
                                      | (~port_ddr_q & pin_in)) & ~sel_mask);
            `SADC_IDX_DDR:  rd_mux = 8'(port_ddr_q);
            default:        rd_mux = 8'h00;
         endcase
      end
   end

   // one wait state: data are loaded while waitrequest is high
   always_ff @(posedge clk) begin
      if (srst) begin
         waitrequest <= 1'h1;
         readdata    <= 32'h0000_0000;
      end else begin
         waitrequest <= ~((avl_req.read | avl_req.write) & waitrequest);
         if (avl_req.read & waitrequest) begin
            readdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         scr_q <= sadc_scr_type'(`SADC_SCR_RST); // [R14] [R12]
      end else begin
         if (wr_scr) begin
            scr_q.conv_irq_enable   <= wbyte[`SADC_SCR_IRQEN];
            scr_q.continuous_enable <= wbyte[`SADC_SCR_CONT];
            scr_q.channel_select    <= wbyte[4:0];
            // writable selector only with interrupts on [R12] [R11]
            scr_q.complete_or_service_select <=
               wbyte[`SADC_SCR_CMPL] & wbyte[`SADC_SCR_IRQEN];
         end else if (rd_data && !scr_q.conv_irq_enable) begin
            scr_q.complete_or_service_select <= 1'h0; // [R11]
         end
         // a completion beats a same-cycle clear [R11] [R08]
         if (sar_done && !scr_q.conv_irq_enable
             && !(wr_scr && wbyte[`SADC_SCR_IRQEN])
             && (!scr_q.continuous_enable || !first_done_q)) begin
            scr_q.complete_or_service_select <= 1'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || wr_scr) begin
         first_done_q <= 1'h0;
      end else if (sar_done) begin
         first_done_q <= 1'h1; // [R08]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         result_q <= 8'h00;
      end else if (sar_done) begin
         result_q <= sar_result; // unread data are lost [R06] [R22]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_pend_q <= 1'h0;
      end else if (sar_done && scr_q.conv_irq_enable) begin
         irq_pend_q <= 1'h1; // [R10]
      end else if (wr_scr || rd_data) begin
         irq_pend_q <= 1'h0; // [R13]
      end
   end

   // a dma choice masks the cpu request; nothing services it here [R19]
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_cpu <= 1'h0;
         irq_dma <= 1'h0;
      end else begin
         irq_cpu <= irq_pend_q & scr_q.conv_irq_enable
                    & ~scr_q.complete_or_service_select; // [R10] [R16]
         irq_dma <= irq_pend_q & scr_q.conv_irq_enable
                    & scr_q.complete_or_service_select; // [R10]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         clksel_q <= `SADC_CLK_RST; // [R24]
      end else if (wr_en && idx == `SADC_IDX_CLK) begin
         clksel_q <= {wbyte[7:4], 4'h0}; // [R23]
      end
   end

   // stored as written; the pin drive and the port read are masked [R02]
   always_ff @(posedge clk) begin
      if (srst) begin
         port_out_q <= '0;
         port_ddr_q <= '0;
      end else begin
         if (wr_en && idx == `SADC_IDX_PORT) begin
            port_out_q <= wbyte[NP-1:0];
         end
         if (wr_en && idx == `SADC_IDX_DDR) begin
            port_ddr_q <= wbyte[NP-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_oe     <= '0;
         pin_out    <= '0;
         analog_sel <= '0;
         adc_power  <= 1'h0;
      end else begin
         pin_oe     <= port_ddr_q & ~sel_mask; // [R01] [R02]
         pin_out    <= port_out_q & ~sel_mask; // [R02]
         analog_sel <= sel_mask; // [R01]
         adc_power  <= !chan_off && !stop_mode; // [R15] [R17]
      end
   end

   // stop kills the conversion; it is restarted once stop ends
   always_ff @(posedge clk) begin
      if (srst) begin
         resume_q <= 1'h0;
         stop_q   <= 1'h0;
      end else begin
         stop_q <= stop_mode;
         if (stop_mode && (sar_busy || scr_q.continuous_enable)) begin
            resume_q <= 1'h1; // [R17]
         end else if (sar_start) begin
            resume_q <= 1'h0;
         end
      end
   end

   // analog needs one conversion after power-up or stop exit [R25] [R20]
   always_ff @(posedge clk) begin
      if (srst) begin
         settle_pend_q <= 1'h0;
         settling_q    <= 1'h0;
      end else begin
         if (sar_done) begin
            settling_q    <= settle_pend_q; // [R25]
            settle_pend_q <= 1'h0;
         end
         if ((wr_scr && chan_off && !new_off) || (stop_q && !stop_mode)) begin
            settle_pend_q <= 1'h1;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_irq_ack;
      (rd_data || wr_scr) && !sar_done;
   endsequence

   a_pin_released: assert property ( // [R01]
      (pin_oe & analog_sel) == '0)
      else $error("selected pin still driven by the port");

   a_port_read_zero: assert property ( // [R03]
      rd_en && idx == `SADC_IDX_PORT |-> (readdata[NP-1:0] & sel_mask) == '0)
      else $error("selected pin did not read as zero");

   a_ref_high_full: assert property ( // [R04]
      sar_done && scr_q.channel_select == `SADC_CH_REFH |=> result_q == 8'hFF)
      else $error("high reference did not convert to full scale");

   a_cont_restart: assert property ( // [R07]
      sar_done && scr_q.continuous_enable && !chan_off && !stop_mode |=> sar_busy)
      else $error("continuous mode did not restart");

   a_single_idle: assert property ( // [R09]
      sar_done && !scr_q.continuous_enable && !wr_scr && !resume_q
      |=> !sar_busy ##1 (!sar_busy || $past(wr_scr)))
      else $error("single mode converted again without a write");

   a_cont_flag_once: assert property ( // [R08]
      sar_done && scr_q.continuous_enable && first_done_q && !wr_scr && !rd_data
      && !scr_q.complete_or_service_select
      |=> !scr_q.complete_or_service_select)
      else $error("complete flag set after a later continuous result");

   a_irq_withdraw: assert property ( // [R13]
      s_irq_ack |=> !irq_pend_q ##1 !irq_cpu && !irq_dma)
      else $error("interrupt still pending after acknowledge");

   a_irq_route: assert property ( // [R10]
      irq_pend_q && scr_q.conv_irq_enable && $stable(scr_q)
      |=> irq_cpu == !$past(scr_q.complete_or_service_select)
          && irq_dma == $past(scr_q.complete_or_service_select))
      else $error("interrupt routed to the wrong service");

   a_power_off: assert property ( // [R15]
      chan_off && !wr_scr |=> !sar_busy && !adc_power)
      else $error("converter active on the power-off code");

   a_stop_abort: assert property ( // [R17]
      stop_mode |=> !sar_busy && !adc_power)
      else $error("converter active in stop mode");
endmodule

/* dv/tb_sadc_top.sv */
/*
 self-checking bench for the sar converter sequencer top: register bus,
 pin takeover, single and continuous runs, irq routing, power-off, stop.
 assumes the logic/ files compile first; the bench models the comparator.
*/
`timescale 1ns/1ps
`include "sadc_params.svh"
module tb_sadc_top;
   import sadc_pkg::*;
   localparam logic [9:0] A_SCR = 10'h0F0;
   localparam logic [9:0] A_DAT = 10'h0F4;
   localparam logic [9:0] A_CLK = 10'h0F8;
   localparam logic [9:0] A_PRT = 10'h0FC;
   localparam logic [9:0] A_DDR = 10'h100;
   localparam int         CW    = 76;
   logic             clk, srst, osc_clock, stop_mode, cmp_above, waitrequest;
   logic             adc_power, irq_cpu, irq_dma;
   sadc_avl_req_type avl_req;
   logic [31:0]      readdata;
   logic [5:0]       pin_in, pin_out, pin_oe, analog_sel;
   logic [7:0]       dac_code, level, v, w;
   logic [31:0]      exp_q[$];
   logic [7:0]       codes[3] = '{8'h1D, 8'h1E, 8'h06};
   logic [7:0]       exp_r[3] = '{8'hFF, 8'h00, 8'h00};
   int               num_errors, n_tests, cyc, seed;

   sadc_top sadc_top_inst (.clk(clk), .srst(srst), .avl_req(avl_req), .readdata(readdata),
      .waitrequest(waitrequest), .osc_clock(osc_clock), .stop_mode(stop_mode),
      .cmp_above(cmp_above), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .analog_sel(analog_sel), .dac_code(dac_code), .adc_power(adc_power),
      .irq_cpu(irq_cpu), .irq_dma(irq_dma));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // comparator model and oscillator pulses every third clk
   always @(posedge clk) begin
      cyc <= cyc + 1;
      osc_clock <= (cyc % 3 == 0);
      cmp_above <= (level >= dac_code);
      pin_in <= 6'($random(seed));
      if (cyc == 20000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avl_req.address <= a;
      avl_req.read <= !wr;
      avl_req.write <= wr;
      avl_req.byteenable <= 4'hF;
      avl_req.writedata <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) num_errors++;
      avl_req.read <= 1'b0;
      avl_req.write <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00);
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   // read data are compared at the accept edge against the oldest note
   always @(posedge clk) begin
      if (avl_req.read === 1'b1 && waitrequest === 1'b0) begin
         if (exp_q.size() == 0) num_errors++;
         else chk(readdata, exp_q.pop_front());
      end
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      seed = 32'h22f7;
      srst = 1'b1;
      stop_mode = 1'b0;
      osc_clock = 1'b0;
      cmp_above = 1'b0;
      pin_in = 6'h00;
      level = 8'h00;
      cyc = 0;
      avl_req = '0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      chk(32'(adc_power), 32'h0);
      rd(A_SCR, 8'h1F);
      rd(A_CLK, 8'h00);
      rd(A_DAT, 8'h00);
      rd(10'h200, 8'h00);
      tend("reset");
      wr(A_CLK, 8'h50);
      wr(A_DDR, 8'h3F);
      wr(A_PRT, 8'h3F);
      v = 8'($random(seed));
      level <= v;
      wr(A_SCR, 8'h02);
      wt(2);
      chk(32'(analog_sel), 32'h04);
      chk(32'(pin_oe), 32'h3B);
      chk(32'(pin_out), 32'h3B);
      chk(32'(adc_power), 32'h1);
      rd(A_PRT, 8'h3B);
      wt(50);
      rd(A_DAT, 8'h00);
      wt(20);
      rd(A_SCR, 8'h82);
      rd(A_CLK, 8'h51);
      rd(A_DAT, v);
      rd(A_SCR, 8'h02);
      wt(80);
      rd(A_SCR, 8'h02);
      tend("single");
      wr(A_SCR, 8'h42);
      wt(CW);
      chk(32'({irq_cpu, irq_dma}), 32'h2);
      rd(A_SCR, 8'h42);
      rd(A_DAT, v);
      wt(2);
      chk(32'(irq_cpu), 32'h0);
      wr(A_SCR, 8'hC2);
      wt(CW);
      chk(32'({irq_cpu, irq_dma}), 32'h1);
      wr(A_SCR, 8'h02); // dma choice withdrawn at once
      wt(2);
      chk(32'(irq_dma), 32'h0);
      wt(CW);
      rd(A_DAT, v);
      tend("irq");
      wr(A_SCR, 8'h22);
      wt(CW);
      rd(A_SCR, 8'hA2);
      rd(A_DAT, v);
      v = 8'($random(seed));
      level <= v;
      wt(CW);
      rd(A_SCR, 8'h22);
      rd(A_DAT, v);
      wr(A_SCR, 8'h1F);
      wt(2);
      chk(32'({adc_power, pin_oe}), 32'h3F);
      level <= ~v;
      wt(2 * CW);
      rd(A_DAT, v);
      tend("continuous");
      // stop entered mid-conversion; the run resumes on exit
      wr(A_SCR, 8'h02);
      wt(30);
      stop_mode <= 1'b1;
      w = 8'($random(seed));
      level <= w;
      wt(2);
      chk(32'(adc_power), 32'h0);
      wt(120);
      rd(A_DAT, v);
      stop_mode <= 1'b0;
      wt(CW + 4);
      rd(A_DAT, w);
      rd(A_CLK, 8'h51);
      tend("stop");
      for (int ch = 0; ch < 6; ch++) begin
         wr(A_SCR, 8'(ch));
         wt(2);
         chk(32'(analog_sel), 32'(6'h01 << ch));
      end
      // oscillator source divided by 4 gives a tick near 1 MHz
      wr(A_CLK, 8'h40);
      level <= 8'h80;
      for (int i = 0; i < 3; i++) begin
         wr(A_SCR, codes[i]);
         wt(210);
         rd(A_DAT, exp_r[i]);
         chk(32'(analog_sel), 32'h0);
      end
      tend("codes");
      wt(4);
      complete_run();
   end
endmodule
